// file: inc/gev_pkg.sv
// constants and field layout of the general-purpose event logic
// Notes on behaviour
// - socket 0 video enable change sets bit 15
// - socket 1 video enable change sets bit 14
// - any socket supply setting change sets bit 11
// - programming voltage to/from 12 V sets bit 8
// - terminals 5,4,2,1,0 changes set bits 4..0
// - write one clears flag and its event
// - flags captured regardless of enable bits
// - reserved bits read-only, always read zero
// - set enable lets its flag drive event
// - event held until enabled flags cleared
// - event reaches pin only if routed there
// - terminal enable counts only for input terminals
// - both registers reset to all zeros
package gev_pkg;

    // ****************************************************
    // register map (configuration space, function 0)
    // ****************************************************
    localparam logic [7:0]  STATUS_OFFSET  = 8'hA8;
    localparam logic [7:0]  ENABLE_OFFSET  = 8'hAA;
    localparam logic        OWN_FUNCTION   = 1'h0;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [15:0] ENABLE_RESET   = 16'h0000;
    localparam logic [15:0] LIVE_BITS_MASK = 16'hC91F;

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int SOCK0_VIDEO_BIT = 15;
    localparam int SOCK1_VIDEO_BIT = 14;
    localparam int POWER_CHG_BIT   = 11;
    localparam int HIGH_VPP_BIT    = 8;
    localparam int TERM_FIELD_LSB  = 0;

    // ****************************************************
    // supply setting encodings and startup count end value
    // ****************************************************
    localparam int          SEL_WIDTH   = 3;
    localparam logic [2:0]  VPP_SEL_12V = 3'h3;
    localparam logic [1:0]  ARM_DONE    = 2'h3;

endpackage : gev_pkg

// file: rtl/gev_event_logic.sv
// general-purpose event status and enable registers with event output
`timescale 1ns/1ns
module gev_event_logic #(
    parameter int PIN_COUNT = 7
) (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic                 cfg_rd,
    input  wire logic                 cfg_wr,
    input  wire logic                 cfg_func,
    input  wire logic [7:0]           cfg_addr,
    input  wire logic [1:0]           cfg_byte_en,
    input  wire logic [15:0]          cfg_wdata,
    output logic      [15:0]          cfg_rdata,
    output logic                      cfg_ack,
    input  wire logic [1:0]           zoom_video_on,
    input  wire logic [2:0]           sock0_vcc_sel,
    input  wire logic [2:0]           sock0_vpp_sel,
    input  wire logic [2:0]           sock1_vcc_sel,
    input  wire logic [2:0]           sock1_vpp_sel,
    input  wire logic [PIN_COUNT-1:0] multi_pins_in,
    input  wire logic [PIN_COUNT-1:0] pin_is_event_out,
    input  wire logic [PIN_COUNT-1:0] pin_is_gp_input,
    output logic      [PIN_COUNT-1:0] multi_pins_out,
    output logic      [PIN_COUNT-1:0] multi_pins_oe_n,
    output logic                      general_event_out
);

    // ****************************************************
    // declarations
    // ****************************************************
    localparam int TERMS = 5;

    logic [15:0]      status_reg;
    logic [15:0]      status_next;
    logic [15:0]      enable_reg;
    logic [15:0]      enable_next;
    logic [15:0]      rdata_reg;
    logic [15:0]      rdata_next;
    logic             ack_reg;
    logic             ack_next;
    logic [1:0]       zv_prev_reg;
    logic [1:0]       zv_prev_next;
    logic [11:0]      pwr_prev_reg;
    logic [11:0]      pwr_prev_next;
    logic [1:0]       arm_reg;
    logic [1:0]       arm_next;
    logic             evt_reg;
    logic             evt_next;
    logic [PIN_COUNT-1:0] pin_out_reg;
    logic [PIN_COUNT-1:0] pin_out_next;
    logic [PIN_COUNT-1:0] pin_oe_n_reg;
    logic [PIN_COUNT-1:0] pin_oe_n_next;
    logic [TERMS-1:0] term_raw;
    logic [TERMS-1:0] term_chg;
    logic [TERMS-1:0] term_is_input;
    logic [15:0]      set_vec;
    logic [15:0]      clr_vec;
    logic [15:0]      gate_vec;
    logic [15:0]      wr_mask;
    logic [11:0]      pwr_now;
    logic             armed;
    logic             hit_status;
    logic             hit_enable;
    logic             vpp12_chg;

    // decode of one register for the own function only
    function automatic logic reg_hit(input logic func, input logic [7:0] addr,
                                     input logic [7:0] offset);
        reg_hit = (func == gev_pkg::OWN_FUNCTION) && (addr == offset);
    endfunction : reg_hit

    // ****************************************************
    // terminal inputs: pins 5,4,2,1,0 feed flag bits 4..0
    // ****************************************************
    assign term_raw      = {multi_pins_in[5], multi_pins_in[4], multi_pins_in[2],
                            multi_pins_in[1], multi_pins_in[0]};
    assign term_is_input = {pin_is_gp_input[5], pin_is_gp_input[4], pin_is_gp_input[2],
                            pin_is_gp_input[1], pin_is_gp_input[0]};

    gev_in_sync #(
        .WIDTH        (TERMS)
    ) u_term_sync (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .async_in     (term_raw),
        .level_out    (),
        .change_pulse (term_chg)
    );

    // ****************************************************
    // access decode and event detection
    // ****************************************************
    // function 1 accesses miss both registers and read zero
    assign hit_status = reg_hit(cfg_func, cfg_addr, gev_pkg::STATUS_OFFSET);
    assign hit_enable = reg_hit(cfg_func, cfg_addr, gev_pkg::ENABLE_OFFSET);
    assign wr_mask    = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
    assign pwr_now    = {sock1_vpp_sel, sock1_vcc_sel, sock0_vpp_sel, sock0_vcc_sel};
    // startup lets the synchroniser and history fill, avoiding false events
    assign armed      = (arm_reg == gev_pkg::ARM_DONE);
    // only crossings of the 12 V code count, not moves between low levels
    assign vpp12_chg  = ((sock0_vpp_sel == gev_pkg::VPP_SEL_12V) !=
                         (pwr_prev_reg[5:3] == gev_pkg::VPP_SEL_12V)) ||
                        ((sock1_vpp_sel == gev_pkg::VPP_SEL_12V) !=
                         (pwr_prev_reg[11:9] == gev_pkg::VPP_SEL_12V));

    // set vector of hardware events, independent of the enables
    always_comb begin
        set_vec = '0;
        if (armed) begin
            set_vec[gev_pkg::SOCK0_VIDEO_BIT] = zoom_video_on[0] ^ zv_prev_reg[0];
            set_vec[gev_pkg::SOCK1_VIDEO_BIT] = zoom_video_on[1] ^ zv_prev_reg[1];
            set_vec[gev_pkg::POWER_CHG_BIT]   = (pwr_now != pwr_prev_reg);
            set_vec[gev_pkg::HIGH_VPP_BIT]    = vpp12_chg;
            set_vec[gev_pkg::TERM_FIELD_LSB +: TERMS] = term_chg;
        end
    end

    // ****************************************************
    // register state
    // ****************************************************
    // write one clears, set beats a clear in the same cycle
    always_comb begin
        clr_vec = '0;
        if (cfg_wr && hit_status) begin
            clr_vec = cfg_wdata & wr_mask & gev_pkg::LIVE_BITS_MASK;
        end
        status_next = ((status_reg & ~clr_vec) | set_vec) & gev_pkg::LIVE_BITS_MASK;
        enable_next = enable_reg;
        if (cfg_wr && hit_enable) begin
            enable_next = ((cfg_wdata & wr_mask) | (enable_reg & ~wr_mask))
                          & gev_pkg::LIVE_BITS_MASK;
        end
    end

    // history of the watched controls and startup count
    always_comb begin
        zv_prev_next  = zoom_video_on;
        pwr_prev_next = pwr_now;
        arm_next      = armed ? arm_reg : arm_reg + 2'h1;
    end

    // reads answer one cycle after the strobe; misses read zero
    always_comb begin
        ack_next   = cfg_rd | cfg_wr;
        rdata_next = '0;
        if (cfg_rd && hit_status) begin
            rdata_next = status_reg;
        end else if (cfg_rd && hit_enable) begin
            rdata_next = enable_reg;
        end
    end

    // event: enabled flags, terminal bits only for input terminals
    always_comb begin
        gate_vec = gev_pkg::LIVE_BITS_MASK;
        gate_vec[gev_pkg::TERM_FIELD_LSB +: TERMS] = term_is_input;
        evt_next = |(status_next & enable_next & gate_vec);
        // drive low only on terminals routed to event signalling
        pin_oe_n_next = ~pin_is_event_out;
        pin_out_next  = {PIN_COUNT{~evt_next}};
    end

    // all registers clear to zero under reset, except the pin output and pin enable registers, which set to all ones
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg   <= gev_pkg::STATUS_RESET;
            enable_reg   <= gev_pkg::ENABLE_RESET;
            rdata_reg    <= '0;
            ack_reg      <= 1'b0;
            zv_prev_reg  <= '0;
            pwr_prev_reg <= '0;
            arm_reg      <= '0;
            evt_reg      <= 1'b0;
            pin_out_reg  <= '1;
            pin_oe_n_reg <= '1;
        end else begin
            status_reg   <= status_next;
            enable_reg   <= enable_next;
            rdata_reg    <= rdata_next;
            ack_reg      <= ack_next;
            zv_prev_reg  <= zv_prev_next;
            pwr_prev_reg <= pwr_prev_next;
            arm_reg      <= arm_next;
            evt_reg      <= evt_next;
            pin_out_reg  <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
        end
    end

    assign cfg_rdata         = rdata_reg;
    assign cfg_ack           = ack_reg;
    assign general_event_out = evt_reg;
    assign multi_pins_out    = pin_out_reg;
    assign multi_pins_oe_n   = pin_oe_n_reg;

    // ****************************************************
    // checks
    // ****************************************************
    chk_zv0_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && zoom_video_on[0] != zv_prev_reg[0]) |=> status_reg[15])
        else $error("socket 0 video change did not set its flag");

    chk_zv1_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && zoom_video_on[1] != zv_prev_reg[1]) |=> status_reg[14])
        else $error("socket 1 video change did not set its flag");

    chk_power_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && pwr_now != pwr_prev_reg) |=> status_reg[11])
        else $error("supply setting change did not set its flag");

    chk_vpp12_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && ($changed(sock0_vpp_sel == gev_pkg::VPP_SEL_12V) ||
                   $changed(sock1_vpp_sel == gev_pkg::VPP_SEL_12V))) |=> status_reg[8])
        else $error("12 V request change did not set its flag");

    chk_term_flag_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && term_chg != '0) |=> ((status_reg[4:0] & $past(term_chg)) == $past(term_chg)))
        else $error("terminal change did not set its flag");

    chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        (|($past(status_reg) & ~status_reg)) |-> $past(cfg_wr && hit_status))
        else $error("status flag fell without a write-one clear");

    chk_capture_unmasked: assert property (@(posedge sys_clk) disable iff (!nrst)
        (armed && enable_reg[15] == 1'b0 && zoom_video_on[0] != zv_prev_reg[0])
        |=> status_reg[15])
        else $error("flag capture depended on the enable bit");

    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        ((status_reg | enable_reg | cfg_rdata) & ~gev_pkg::LIVE_BITS_MASK) == 16'h0000)
        else $error("reserved bit read back nonzero");

    chk_event_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
        (|(status_reg & enable_reg & $past(gate_vec))) |-> general_event_out)
        else $error("event output dropped while an enabled flag stood");

    chk_pin_routing: assert property (@(posedge sys_clk) disable iff (!nrst)
        nrst |=> (multi_pins_oe_n == ~$past(pin_is_event_out)))
        else $error("event driven on a terminal not routed to it");

endmodule : gev_event_logic

// file: rtl/gev_in_sync.sv
// two-stage synchroniser with change detection for terminal inputs
`timescale 1ns/1ns
module gev_in_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] change_pulse
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    // previous value follows the stable stage, compared one cycle later
    always_comb begin
        prev_next = stable_reg;
    end

    // first stage is read only by the second stage, never by logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg   <= '0;
            stable_reg <= '0;
            prev_reg   <= '0;
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
            prev_reg   <= prev_next;
        end
    end

    // one-cycle pulse on every level change
    assign change_pulse = stable_reg ^ prev_reg;
    assign level_out    = stable_reg;

endmodule : gev_in_sync

// file: test/gev_pm_model.sv
// power-management partner that watches the routed event terminal
`timescale 1ns/1ns
module gev_pm_model #(
    parameter int PIN = 6
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [6:0] pin_level,
    output logic            event_seen
);
    // event is active low on the wire; the pull-up keeps it high when undriven
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            event_seen <= 1'b0;
        else
            event_seen <= ~pin_level[PIN];
    end
endmodule : gev_pm_model

// file: test/tb_general_purpose_event_logic.sv
// self-checking testbench for the general-purpose event logic
`timescale 1ns/1ns
module tb_general_purpose_event_logic;
    logic        sys_clk, nrst, cfg_rd, cfg_wr, cfg_func, cfg_ack, gev, event_seen;
    logic [7:0]  cfg_addr;
    logic [1:0]  cfg_byte_en, zoom;
    logic [15:0] cfg_wdata, cfg_rdata, rd;
    logic [2:0]  vcc0, vpp0, vcc1, vpp1;
    logic [6:0]  term_drive, pin_wire, ev_out, gp_in, p_out, p_oe_n;
    int          n_fail, tests_run;
    int          pmap[5] = '{0, 1, 2, 4, 5};

    // terminal level: design drives when enabled, else the outside source
    assign pin_wire = (~p_oe_n & p_out) | (p_oe_n & term_drive);

    gev_event_logic uut (.sys_clk(sys_clk), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .zoom_video_on(zoom), .sock0_vcc_sel(vcc0), .sock0_vpp_sel(vpp0),
        .sock1_vcc_sel(vcc1), .sock1_vpp_sel(vpp1), .multi_pins_in(pin_wire),
        .pin_is_event_out(ev_out), .pin_is_gp_input(gp_in), .multi_pins_out(p_out),
        .multi_pins_oe_n(p_oe_n), .general_event_out(gev));
    gev_pm_model pm (.sys_clk(sys_clk), .nrst(nrst), .pin_level(pin_wire),
        .event_seen(event_seen));

    always #5 sys_clk = ~sys_clk;

    // ****************************************************
    // shared tasks
    // ****************************************************
    task finish_test;
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // one strobe cycle, answer sampled once the ack edge has landed
    task acc(input logic wr, input logic fn, input logic [7:0] a, input logic [1:0] be,
             input logic [15:0] d);
        @(posedge sys_clk);
        cfg_wr      <= wr;
        cfg_rd      <= ~wr;
        cfg_func    <= fn;
        cfg_addr    <= a;
        cfg_byte_en <= be;
        cfg_wdata   <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        rd = cfg_rdata;
        chk1(cfg_ack, 1'b1);
    endtask : acc

    task rdc(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b0, 1'b0, a, 2'h3, 16'h0000);
        chk16(rd, exp);
    endtask : rdc

    // wait for capture, check flags, clear them by write-one
    task settle(input logic [15:0] exp);
        repeat (5) @(posedge sys_clk);
        rdc(8'hA8, exp);
        acc(1'b1, 1'b0, 8'hA8, 2'h3, exp);
        rdc(8'hA8, 16'h0000);
    endtask : settle

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        {sys_clk, nrst, cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
        {zoom, vcc0, vpp0, vcc1, vpp1} = '0;
        term_drive = 7'h7F;
        ev_out     = 7'h40;
        gp_in      = 7'h37;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rdc(8'hA8, 16'h0000);
        rdc(8'hAA, 16'h0000);
        repeat (4) @(posedge sys_clk);
        @(posedge sys_clk) zoom <= 2'h1;
        repeat (5) @(posedge sys_clk);
        rdc(8'hA8, 16'h8000);
        chk1(gev, 1'b0);
        acc(1'b1, 1'b0, 8'hAA, 2'h3, 16'hFFFF);
        rdc(8'hAA, 16'hC91F);
        repeat (2) @(posedge sys_clk);
        chk1(gev, 1'b1);
        chk1(event_seen, 1'b1);
        @(posedge sys_clk) zoom <= 2'h3;
        repeat (5) @(posedge sys_clk);
        acc(1'b1, 1'b0, 8'hA8, 2'h3, 16'h8000);
        repeat (2) @(posedge sys_clk);
        chk1(gev, 1'b1);
        rdc(8'hA8, 16'h4000);
        acc(1'b1, 1'b0, 8'hA8, 2'h3, 16'h4000);
        repeat (2) @(posedge sys_clk);
        chk1(gev, 1'b0);
        // foreign function must neither clear nor return data, unmapped offset must return no data, and both still get an ack
        @(posedge sys_clk) zoom <= 2'h0;
        repeat (5) @(posedge sys_clk);
        acc(1'b1, 1'b1, 8'hA8, 2'h3, 16'hFFFF);
        acc(1'b0, 1'b1, 8'hA8, 2'h3, 16'h0000);
        chk16(rd, 16'h0000);
        acc(1'b0, 1'b0, 8'hAC, 2'h3, 16'h0000);
        chk16(rd, 16'h0000);
        settle(16'hC000);
        acc(1'b1, 1'b0, 8'hAA, 2'h1, 16'h0000);
        rdc(8'hAA, 16'hC900);
        @(posedge sys_clk) vcc0 <= 3'h1;
        settle(16'h0800);
        @(posedge sys_clk) vpp1 <= 3'h3;
        settle(16'h0900);
        @(posedge sys_clk) vpp1 <= 3'h1;
        settle(16'h0900);
        @(posedge sys_clk) vpp0 <= 3'h2;
        settle(16'h0800);
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk) term_drive[pmap[k]] <= ~term_drive[pmap[k]];
            settle(16'h0001 << k);
        end
        // terminal enable counts only while the pin is a plain input
        acc(1'b1, 1'b0, 8'hAA, 2'h3, 16'h0001);
        @(posedge sys_clk) gp_in <= 7'h36;
        @(posedge sys_clk) term_drive[0] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk1(gev, 1'b0);
        @(posedge sys_clk) gp_in <= 7'h37;
        repeat (3) @(posedge sys_clk);
        chk1(gev, 1'b1);
        chk1(event_seen, 1'b1);
        @(posedge sys_clk) ev_out <= 7'h00;
        repeat (3) @(posedge sys_clk);
        chk1(event_seen, 1'b0);
        finish_test;
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
endmodule : tb_general_purpose_event_logic
